// File: rtl/scr_regs.svh
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// register byte offsets
`define SCR_OFS_CTRL       8'h00
`define SCR_OFS_STATUS     8'h04
`define SCR_OFS_MASK       8'h08
`define SCR_OFS_WORD       8'h0C
`define SCR_OFS_PINS       8'h10
`define SCR_OFS_GAIN       8'h14

// ctrl register fields
`define SCR_CTRL_OE_BIT    0
`define SCR_CTRL_RESET     1'h1

// status and mask fields
`define SCR_ST_LATCH_BIT   0
`define SCR_ST_COUNT_BIT   1
`define SCR_ST_OPEN_BIT    2
`define SCR_ST_SHORT_BIT   3
`define SCR_ST_WIDTH       4
`define SCR_MASK_RESET     4'h0

// control word
`define SCR_WORD_BITS      8
`define SCR_WORD_RESET     8'h00
`define SCR_DEFAULT_WORD   8'h00
`define SCR_CNT_WIDTH      4

// idle pin levels {clock, data, select, disable, open_ok, short_ok}
`define SCR_PIN_IDLE       6'h03
`define SCR_FAULT_IDLE     2'h3

`endif

// File: rtl/scr_pkg.sv
package scr_pkg;

  // parallel control word, msb shifted first
  typedef struct packed {
    logic       spare;
    logic       adc_reset;
    logic       high_resolution_select;
    logic [1:0] oversampling_ratio_select;
    logic       excitation_disable;
    logic [1:0] gain_select;
  } scr_word_type;

  // shared serial bus as seen by this register
  typedef struct packed {
    logic shift_clock_pin;
    logic serial_input_pin;
    logic select_pin;
  } scr_spi_type;

  // fault comparator flags, low means fault
  typedef struct packed {
    logic open_ok;
    logic short_ok;
  } scr_fault_type;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scr_bus_req_type;

endpackage

// File: rtl/scr_sync.sv
`timescale 1ns/1ps
module scr_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  // data
  input  wire logic [WIDTH-1:0] i_async,
  output      logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= RESET_VALUE;
    end else begin
      stage1 <= i_async;
    end
  end

  // both stages start at the idle levels so no false edge follows reset
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sync <= RESET_VALUE;
    end else begin
      o_sync <= stage1;
    end
  end

endmodule

// File: rtl/scr_top.sv
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "scr_regs.svh"
module scr_top (
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_arst_n,
  // shared serial bus pins
  input  wire scr_pkg::scr_spi_type    i_spi,
  // output disable pin, high disables
  input  wire logic                    i_output_disable,
  // fault comparator pins
  input  wire scr_pkg::scr_fault_type  i_fault,
  // register port
  input  wire scr_pkg::scr_bus_req_type i_bus,
  output      logic [31:0]             o_rdata,
  // parallel control outputs
  output      scr_pkg::scr_word_type   o_ctrl,
  // fault flags to the monitor, low on fault
  output      scr_pkg::scr_fault_type  o_fault,
  // interrupt
  output      logic                    o_irq
);
  import scr_pkg::*;

  localparam int NPIN = 6;

  function automatic logic [3:0] gain_vv(input logic [1:0] sel);
    gain_vv = {1'b0, sel, 1'b0} + 4'h2;
  endfunction

  logic [NPIN-1:0]                pins_sync;
  logic                           sclk_s;
  logic                           sdi_s;
  logic                           sel_s;
  logic                           dis_s;
  logic                           open_ok_s;
  logic                           short_ok_s;
  logic                           sclk_d;
  logic                           sel_d;
  logic                           open_d;
  logic                           short_d;
  logic                           sclk_rise;
  logic                           sel_rise;
  logic [`SCR_WORD_BITS-1:0]      shifter;
  logic [`SCR_CNT_WIDTH-1:0]      bit_cnt;
  scr_word_type                   latched;
  logic                           sw_oe;
  logic [`SCR_ST_WIDTH-1:0]       status;
  logic [`SCR_ST_WIDTH-1:0]       mask;
  logic [`SCR_ST_WIDTH-1:0]       events;
  logic [`SCR_ST_WIDTH-1:0]       w1c;
  logic                           wr_ctrl;
  logic                           wr_status;
  logic                           wr_mask;
  logic                           outputs_on;
  logic [31:0]                    next_rdata;

  // all pins pass two flip-flops; idle levels: clock low, select low, flags high
  scr_sync #(
    .WIDTH       (NPIN),
    .RESET_VALUE (`SCR_PIN_IDLE)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_async   ({i_spi.shift_clock_pin, i_spi.serial_input_pin, i_spi.select_pin,
                 i_output_disable, i_fault.open_ok, i_fault.short_ok}),
    .o_sync    (pins_sync)
  );

  assign {sclk_s, sdi_s, sel_s, dis_s, open_ok_s, short_ok_s} = pins_sync;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_d  <= 1'b0;
      sel_d   <= 1'b0;
      open_d  <= 1'b1;
      short_d <= 1'b1;
    end else begin
      sclk_d  <= sclk_s;
      sel_d   <= sel_s;
      open_d  <= open_ok_s;
      short_d <= short_ok_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sel_rise  = sel_s & ~sel_d;

  // shift on rising clock, msb first, data line as serial input
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shifter <= `SCR_WORD_RESET;
    end else if (sclk_rise) begin
      shifter <= {shifter[`SCR_WORD_BITS-2:0], sdi_s};
    end
  end

  // bits seen since the last latch, saturating
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt <= '0;
    end else if (sel_rise) begin
      bit_cnt <= '0;
    end else if (sclk_rise && !sel_s && bit_cnt != 4'hF) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // select rising edge transfers the shifted word
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latched <= `SCR_WORD_RESET;
    end else if (sel_rise) begin
      latched <= shifter;
    end
  end

  // disabled outputs take the fixed default levels
  assign outputs_on = sw_oe & ~dis_s;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctrl <= `SCR_DEFAULT_WORD;
    end else begin
      o_ctrl <= outputs_on ? latched : scr_word_type'(`SCR_DEFAULT_WORD);
    end
  end

  // fault flags stay active low toward the monitor
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fault <= `SCR_FAULT_IDLE;
    end else begin
      o_fault <= {open_ok_s, short_ok_s};
    end
  end

  // event sources
  always_comb begin
    events                     = '0;
    events[`SCR_ST_LATCH_BIT]  = sel_rise;
    events[`SCR_ST_COUNT_BIT]  = sel_rise && bit_cnt != `SCR_CNT_WIDTH'(`SCR_WORD_BITS);
    events[`SCR_ST_OPEN_BIT]   = open_d & ~open_ok_s;
    events[`SCR_ST_SHORT_BIT]  = short_d & ~short_ok_s;
  end

  assign wr_ctrl   = i_bus.wr && i_bus.addr == `SCR_OFS_CTRL;
  assign wr_status = i_bus.wr && i_bus.addr == `SCR_OFS_STATUS;
  assign wr_mask   = i_bus.wr && i_bus.addr == `SCR_OFS_MASK;
  assign w1c       = wr_status ? i_bus.wdata[`SCR_ST_WIDTH-1:0] : '0;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_oe <= `SCR_CTRL_RESET;
    end else if (wr_ctrl) begin
      sw_oe <= i_bus.wdata[`SCR_CTRL_OE_BIT];
    end
  end

  // sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~w1c) | events;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask <= `SCR_MASK_RESET;
    end else if (wr_mask) begin
      mask <= i_bus.wdata[`SCR_ST_WIDTH-1:0];
    end
  end

  assign o_irq = |(status & mask);

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `SCR_OFS_CTRL:   next_rdata[`SCR_CTRL_OE_BIT] = sw_oe;
        `SCR_OFS_STATUS: next_rdata[`SCR_ST_WIDTH-1:0] = status;
        `SCR_OFS_MASK:   next_rdata[`SCR_ST_WIDTH-1:0] = mask;
        `SCR_OFS_WORD:   next_rdata[`SCR_WORD_BITS-1:0] = latched;
        `SCR_OFS_PINS:   next_rdata[4:0] = {dis_s, outputs_on, sel_s, open_ok_s, short_ok_s};
        `SCR_OFS_GAIN:   next_rdata[3:0] = gain_vv(o_ctrl.gain_select);
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule

// File: bench/scr_top_monitor.sv
`timescale 1ns/1ps
module scr_top_monitor
  import scr_pkg::*;
(
  input wire logic            i_ref_clk,
  input wire logic            i_arst_n,
  input wire scr_spi_type     i_spi,
  input wire logic            i_output_disable,
  input wire scr_fault_type   i_fault,
  input wire scr_bus_req_type i_bus,
  input wire logic [31:0]     o_rdata,
  input wire scr_word_type    o_ctrl,
  input wire scr_fault_type   o_fault,
  input wire logic            o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_fault_steady; $stable(i_fault) [*5]; endsequence
  sequence s_disabled; i_output_disable [*5]; endsequence
  sequence s_calm; (!i_spi.select_pin && !i_output_disable && !i_bus.wr) [*6]; endsequence
  property p_fault; s_fault_steady |-> o_fault == i_fault; endproperty
  property p_dflt; s_disabled |-> o_ctrl == 8'h00; endproperty
  property p_hold; s_calm |-> $stable(o_ctrl); endproperty
  property p_idle; !$past(i_bus.rd) |-> o_rdata == 32'h0000_0000; endproperty
  property p_unmap; i_bus.rd && i_bus.addr == 8'h20 |=> o_rdata == 32'h0000_0000; endproperty
  property p_upper; i_bus.rd |=> o_rdata[31:8] == 24'h00_0000; endproperty
  property p_gain; i_bus.rd && i_bus.addr == 8'h14
    |=> o_rdata == 32'(2 * ($past(o_ctrl.gain_select) + 1)); endproperty
  property p_irq; i_bus.wr && i_bus.addr == 8'h08 && i_bus.wdata[3:0] == 4'h0 |=> !o_irq;
  endproperty
  a_fault: assert property (p_fault) else $error("fault copy");
  a_dflt: assert property (p_dflt) else $error("default word");
  a_hold: assert property (p_hold) else $error("ctrl moved");
  a_idle: assert property (p_idle) else $error("rdata idle");
  a_unmap: assert property (p_unmap) else $error("unmapped");
  a_upper: assert property (p_upper) else $error("upper bits");
  a_gain: assert property (p_gain) else $error("gain");
  a_irq: assert property (p_irq) else $error("irq masked");
endmodule
bind scr_top scr_top_monitor u_mon (.i_ref_clk, .i_arst_n, .i_spi, .i_output_disable,
  .i_fault, .i_bus, .o_rdata, .o_ctrl, .o_fault, .o_irq);

// File: bench/scr_host_model.sv
`timescale 1ns/1ps
module scr_host_model
  import scr_pkg::*;
(
  input  wire logic        i_ref_clk,
  output      scr_spi_type o_spi
);
  initial o_spi = '0;
  // one frame: select low, n bits msb first, select rises to latch
  task automatic send(input logic [7:0] w, input int n);
    @(posedge i_ref_clk);
    o_spi.select_pin <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge i_ref_clk);
      o_spi.serial_input_pin <= w[i];
      repeat (4) @(posedge i_ref_clk);
      o_spi.shift_clock_pin <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      o_spi.shift_clock_pin <= 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    o_spi.serial_input_pin <= ~o_spi.serial_input_pin;
    o_spi.select_pin <= 1'b1;
  endtask
endmodule

// File: bench/spi_control_shift_register_test.sv
`timescale 1ns/1ps
module spi_control_shift_register_test;
  import scr_pkg::*;
  logic            i_ref_clk = 1'b0;
  logic            i_arst_n = 1'b0;
  logic            dis = 1'b0;
  scr_fault_type   flt = 2'b11;
  scr_bus_req_type bus = '0;
  scr_spi_type     spi;
  logic [31:0]     rdata;
  scr_word_type    ctrl;
  scr_fault_type   fault_o;
  logic            irq;
  int              n_mismatch = 0;
  int              comparisons = 0;
  int              seed = 15;
  int              cycles = 0;
  int              exp_word = 0;
  int              exp_st = 0;
  int              shift_q[$] = '{0, 0, 0, 0, 0, 0, 0, 0};
  initial forever #5 i_ref_clk = ~i_ref_clk;
  scr_host_model host (.i_ref_clk(i_ref_clk), .o_spi(spi));
  scr_top dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_spi(spi), .i_output_disable(dis),
    .i_fault(flt), .i_bus(bus), .o_rdata(rdata), .o_ctrl(ctrl), .o_fault(fault_o), .o_irq(irq));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input int exp, input string what);
    @(posedge i_ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    #1 chk(what, rdata, 32'(exp));
  endtask
  // bit queue model of the shifter: the last eight bits in form the word
  task automatic frame(input int w, input int n);
    host.send(8'(w), n);
    for (int b = n - 1; b >= 0; b--) begin
      shift_q.push_back((w >> b) & 1);
    end
    while (shift_q.size() > 8) begin
      void'(shift_q.pop_front());
    end
    exp_word = 0;
    foreach (shift_q[k]) begin
      exp_word = (exp_word << 1) | shift_q[k];
    end
    exp_st = exp_st | 1 | (n != 8 ? 2 : 0);
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #1 chk("ctrl", 32'(ctrl), 32'h0000_0000);
    chk("fault", 32'(fault_o), 32'h0000_0003);
    rd(8'h00, 1, "ctrl_reg");
    rd(8'h08, 0, "mask");
    for (int i = 0; i < 4; i++) begin
      frame(($random(seed) & 'hFC) | i, 8);
      repeat (6) @(posedge i_ref_clk);
      #1 chk("ctrl", 32'(ctrl), 32'(exp_word));
      rd(8'h0C, exp_word, "word");
      rd(8'h14, 2 * (i + 1), "gain");
    end
    rd(8'h04, exp_st, "status");
    for (int m = 2; m >= 0; m--) begin
      wr(8'h08, 32'(m));
      #1 chk("irq", 32'(irq), 32'(m == 1));
    end
    wr(8'h04, 32'h0000_000F);
    rd(8'h04, 0, "status");
    exp_st = 0;
    frame('h55, 7);
    repeat (6) @(posedge i_ref_clk);
    #1 chk("ctrl", 32'(ctrl), 32'(exp_word));
    rd(8'h04, exp_st, "status");
    @(posedge i_ref_clk);
    dis <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    #1 chk("ctrl", 32'(ctrl), 32'h0000_0000);
    @(posedge i_ref_clk);
    dis <= 1'b0;
    flt <= 2'b00;
    repeat (8) @(posedge i_ref_clk);
    #1 chk("ctrl", 32'(ctrl), 32'(exp_word));
    chk("fault", 32'(fault_o), 32'h0000_0000);
    exp_st = exp_st | 'hC;
    rd(8'h04, exp_st, "status");
    wr(8'h20, 32'h0000_0000);
    rd(8'h20, 0, "unmapped");
    rd(8'h10, 'h0C, "pins");
    wr(8'h00, 32'h0000_0000);
    @(posedge i_ref_clk);
    #1 chk("ctrl", 32'(ctrl), 32'h0000_0000);
    rd(8'h00, 0, "ctrl_reg");
    wr(8'h00, 32'h0000_0001);
    rd(8'h00, 1, "ctrl_reg");
    give_verdict();
  end
endmodule
